// ===== core/svd_ctrl.sv
// Purpose: Supply voltage detector control, event flag and AXI4-Lite registers.
// Assumes: Comparator level supply_low is synchronous to aclk.
// Notes:   Analog divider, reference and comparator sit outside this block.
//
// Operation
// R01 - Control bit 7 switches monitor on/off
// R02 - Toggling enable raises no false event
// R03 - Bit 4 reads ready after stabilisation
// R04 - No interrupt before ready after enable
// R05 - Rise select sets flag at/above limit
// R06 - Fall select sets flag at/below limit
// R07 - Both selects flag either direction
// R08 - Bit 5 shows comparator: 1 at/below
// R09 - Level register bits 3:0, 1111 reserved
// R10 - Level clears only on power-on/brown-out
// R11 - Flag set when trip reached, enabled direction
// R12 - Start-up interval timed, detection held off
// R13 - Runs in Sleep, flag wakes device
// R14 - Keeps running in Idle and Doze
// R15 - Device reset turns monitor off
// R16 - Software disables before changing settings
// R17 - Software follows setup order
// R18 - Flag sticky, re-sets if condition persists
// R19 - Interrupt only with flag and enable
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module svd_ctrl #(
  parameter int unsigned STARTUP_CYCLES = svd_pkg::STARTUP_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        por_reset,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        supply_low,
  input  wire logic        global_irq_en,
  output logic             monitor_on,
  output logic [3:0]       trip_level,
  output logic             wake_req,
  output logic             irq
);
  if (STARTUP_CYCLES < 1)
  begin : g_chk
    $error("svd_ctrl: STARTUP_CYCLES must be at least 1");
  end

  svd_tmr_if tmr ();

  svd_startup_timer #(
    .CYCLES (STARTUP_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr.timer)
  );

  logic              rise_detect_en;
  logic              fall_detect_en;
  logic              detect_flag;
  logic              detect_irq_en;
  logic              next_monitor_on;
  logic              next_rise_detect_en;
  logic              next_fall_detect_en;
  logic [3:0]        next_trip_level;
  logic              next_detect_flag;
  logic              next_detect_irq_en;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [1:0]        next_rresp;
  logic [31:0]       next_rdata;
  logic              wr_fire;
  logic              rd_fire;
  logic              wr_lane0;
  logic              flag_clr;
  logic              trip_event;
  logic              ready;
  svd_pkg::svd_sel_e wsel;
  svd_pkg::svd_sel_e rsel;

  // Bus handshakes: write address and data taken together
  assign wsel     = svd_pkg::svd_decode(awaddr);
  assign rsel     = svd_pkg::svd_decode(araddr);
  assign wr_fire  = awvalid && wvalid && !bvalid;
  assign awready  = wr_fire;
  assign wready   = wr_fire;
  assign rd_fire  = arvalid && !rvalid;
  assign arready  = !rvalid;
  assign wr_lane0 = wr_fire && wstrb[0];

  // Timer is armed by the enable; gating by the enable blanks detection in the disabling cycle
  assign tmr.arm = monitor_on;                  // R12
  assign ready   = tmr.ready && monitor_on;     // R03 R02

  // Detection gated by readiness; a fresh enable cannot trip early
  assign trip_event = ready
                      && ((rise_detect_en && !supply_low)    // R05
                      || (fall_detect_en && supply_low));    // R06 R07 R11 R02 R04

  // Flag clear by writing one to the flag position
  assign flag_clr = wr_lane0 && (wsel == svd_pkg::SVD_SEL_IRQ) && wdata[svd_pkg::FLAG_BIT];

  // Wake works in every power mode; vectoring needs the global enable
  assign wake_req = detect_flag && detect_irq_en;   // R13 R14
  assign irq      = wake_req && global_irq_en;      // R19

  // Register file next values
  always_comb
  begin
    next_monitor_on     = monitor_on;
    next_rise_detect_en = rise_detect_en;
    next_fall_detect_en = fall_detect_en;
    next_trip_level     = trip_level;
    next_detect_irq_en  = detect_irq_en;
    if (wr_lane0 && (wsel == svd_pkg::SVD_SEL_CTRL))
    begin
      next_monitor_on     = wdata[svd_pkg::ON_BIT];     // R01
      next_rise_detect_en = wdata[svd_pkg::RISE_BIT];
      next_fall_detect_en = wdata[svd_pkg::FALL_BIT];
    end
    else if (wr_lane0 && (wsel == svd_pkg::SVD_SEL_LEVEL)
             && (wdata[svd_pkg::LEVEL_W-1:0] != svd_pkg::LEVEL_RESERVED))
      next_trip_level = wdata[svd_pkg::LEVEL_W-1:0];    // R09
    else if (wr_lane0 && (wsel == svd_pkg::SVD_SEL_IRQ))
      next_detect_irq_en = wdata[svd_pkg::IE_BIT];
    // A trip in the clearing cycle wins over the clear
    next_detect_flag = trip_event || (detect_flag && !flag_clr);   // R18
  end

  // Device reset clears all but the level field
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      monitor_on     <= 1'b0;   // R15
      rise_detect_en <= 1'b0;
      fall_detect_en <= 1'b0;
      detect_flag    <= 1'b0;
      detect_irq_en  <= 1'b0;
    end
    else
    begin
      monitor_on     <= next_monitor_on;
      rise_detect_en <= next_rise_detect_en;
      fall_detect_en <= next_fall_detect_en;
      detect_flag    <= next_detect_flag;
      detect_irq_en  <= next_detect_irq_en;
    end
  end

  // Level survives ordinary resets, cleared only by power-on or brown-out
  always_ff @(posedge aclk)
  begin
    if (por_reset)
      trip_level <= svd_pkg::LEVEL_RST;   // R10
    else if (aresetn)
      trip_level <= next_trip_level;
  end

  // Response channels next values
  always_comb
  begin
    next_bvalid = bvalid;
    next_bresp  = bresp;
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (bvalid && bready)
      next_bvalid = 1'b0;
    if (wr_fire)
    begin
      next_bvalid = 1'b1;
      next_bresp  = (wsel == svd_pkg::SVD_SEL_NONE) ? svd_pkg::RESP_SLVERR : svd_pkg::RESP_OKAY;
    end
    if (rvalid && rready)
      next_rvalid = 1'b0;
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rresp  = svd_pkg::RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      if (rsel == svd_pkg::SVD_SEL_CTRL)
      begin
        next_rdata[svd_pkg::ON_BIT]   = monitor_on;
        next_rdata[svd_pkg::OUT_BIT]  = monitor_on && supply_low;   // R08
        next_rdata[svd_pkg::RDY_BIT]  = ready;                      // R03
        next_rdata[svd_pkg::RISE_BIT] = rise_detect_en;
        next_rdata[svd_pkg::FALL_BIT] = fall_detect_en;
      end
      else if (rsel == svd_pkg::SVD_SEL_LEVEL)
        next_rdata[svd_pkg::LEVEL_W-1:0] = trip_level;
      else if (rsel == svd_pkg::SVD_SEL_IRQ)
      begin
        next_rdata[svd_pkg::FLAG_BIT] = detect_flag;
        next_rdata[svd_pkg::IE_BIT]   = detect_irq_en;
      end
      else
        next_rresp = svd_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp  <= svd_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rresp  <= svd_pkg::RESP_OKAY;
      rdata  <= 32'h0000_0000;
    end
    else
    begin
      bvalid <= next_bvalid;
      bresp  <= next_bresp;
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // Checks on enable, readiness and flag behaviour
  property p_on_write;
    @(posedge aclk) disable iff (!aresetn)
    (wr_lane0 && wsel == svd_pkg::SVD_SEL_CTRL) |=> (monitor_on == $past(wdata[svd_pkg::ON_BIT]));
  endproperty
  a_on_write: assert property (p_on_write) else $error("enable bit not written"); // R01

  property p_ready_on;
    @(posedge aclk) disable iff (!aresetn)
    ready |-> monitor_on;
  endproperty
  a_ready_on: assert property (p_ready_on) else $error("ready while disabled"); // R03

  property p_ready_holdoff;
    @(posedge aclk) disable iff (!aresetn)
    $rose(monitor_on) |-> !ready ##1 !ready;
  endproperty
  a_ready_holdoff: assert property (p_ready_holdoff) else $error("ready too early"); // R12

  property p_flag_needs_ready;
    @(posedge aclk) disable iff (!aresetn)
    $rose(detect_flag) |-> $past(ready);
  endproperty
  a_flag_needs_ready: assert property (p_flag_needs_ready) else $error("flag before ready"); // R04

  property p_rise_sets;
    @(posedge aclk) disable iff (!aresetn)
    (ready && rise_detect_en && !supply_low) |=> detect_flag;
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("rise trip missed"); // R05

  property p_fall_sets;
    @(posedge aclk) disable iff (!aresetn)
    (ready && fall_detect_en && supply_low) |=> detect_flag;
  endproperty
  a_fall_sets: assert property (p_fall_sets) else $error("fall trip missed"); // R06

  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
    (detect_flag && !flag_clr) |=> detect_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear"); // R18

  property p_irq;
    @(posedge aclk) disable iff (!aresetn)
    irq == (detect_flag && detect_irq_en && global_irq_en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch"); // R19

  property p_reset_off;
    @(posedge aclk)
    !aresetn |=> (!monitor_on && !detect_flag && !ready);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset left monitor on"); // R15

  property p_level_por;
    @(posedge aclk)
    por_reset |=> (trip_level == svd_pkg::LEVEL_RST);
  endproperty
  a_level_por: assert property (p_level_por) else $error("level not cleared"); // R10

  // Clear, reserved code and comparator read-back
  property p_flag_clears;
    @(posedge aclk) disable iff (!aresetn)
    (flag_clr && !trip_event) |=> !detect_flag;
  endproperty
  a_flag_clears: assert property (p_flag_clears) else $error("flag not cleared"); // R18

  property p_set_wins;
    @(posedge aclk) disable iff (!aresetn)
    (flag_clr && trip_event) |=> detect_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a live trip"); // R18

  property p_no_event_idle;
    @(posedge aclk) disable iff (!aresetn)
    (!ready && !detect_flag) |=> !detect_flag;
  endproperty
  a_no_event_idle: assert property (p_no_event_idle) else $error("event while not ready"); // R02

  property p_level_write;
    @(posedge aclk) disable iff (!aresetn)
    (wr_lane0 && wsel == svd_pkg::SVD_SEL_LEVEL && !por_reset
     && wdata[svd_pkg::LEVEL_W-1:0] != svd_pkg::LEVEL_RESERVED)
    |=> (trip_level == $past(wdata[svd_pkg::LEVEL_W-1:0]));
  endproperty
  a_level_write: assert property (p_level_write) else $error("level not written"); // R09

  property p_level_reserved;
    @(posedge aclk) disable iff (!aresetn)
    (wr_lane0 && wsel == svd_pkg::SVD_SEL_LEVEL && !por_reset
     && wdata[svd_pkg::LEVEL_W-1:0] == svd_pkg::LEVEL_RESERVED) |=> $stable(trip_level);
  endproperty
  a_level_reserved: assert property (p_level_reserved) else $error("reserved level taken"); // R09

  property p_out_bit;
    @(posedge aclk) disable iff (!aresetn)
    (rd_fire && rsel == svd_pkg::SVD_SEL_CTRL && monitor_on)
    |=> (rdata[svd_pkg::OUT_BIT] == $past(supply_low));
  endproperty
  a_out_bit: assert property (p_out_bit) else $error("comparator bit wrong"); // R08

  c_rise: cover property (@(posedge aclk) disable iff (!aresetn)
    rise_detect_en && $rose(detect_flag));
  c_fall: cover property (@(posedge aclk) disable iff (!aresetn)
    fall_detect_en && $rose(detect_flag));
  c_ready: cover property (@(posedge aclk) disable iff (!aresetn) $rose(ready));
  c_clear: cover property (@(posedge aclk) disable iff (!aresetn) $fell(detect_flag));
  c_wake: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq));

endmodule : svd_ctrl

// ===== core/svd_startup_timer.sv
// Purpose: Holds off readiness for the reference start-up interval after arming.
// Assumes: Interval expressed in cycles of the 125 MHz system clock.
// Notes:   Dropping arm restarts the whole interval on the next arm.
`timescale 1ns/1ns
module svd_startup_timer #(
  parameter int unsigned CYCLES = svd_pkg::STARTUP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  svd_tmr_if.timer tmr
);
  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef enum logic [1:0] {
    SVD_T_OFF,
    SVD_T_WARM,
    SVD_T_READY
  } svd_tstate_e;

  svd_tstate_e   state;
  svd_tstate_e   next_state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  if (CYCLES < 1)
  begin : g_chk
    $error("svd_startup_timer: CYCLES must be at least 1");
  end

  // Warm-up count restarts from zero on every arm
  always_comb
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      SVD_T_OFF:
      begin
        next_cnt = '0;
        if (tmr.arm)
          next_state = SVD_T_WARM;
      end
      SVD_T_WARM:
      begin
        if (!tmr.arm)
          next_state = SVD_T_OFF;
        else if (cnt == CW'(CYCLES - 1))
          next_state = SVD_T_READY;
        else
          next_cnt = cnt + CW'(1);
      end
      SVD_T_READY:
      begin
        if (!tmr.arm)
          next_state = SVD_T_OFF;
      end
      default:
        next_state = SVD_T_OFF;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= SVD_T_OFF;
      cnt   <= '0;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Ready falls on the clock edge after arm drops
  assign tmr.ready = (state == SVD_T_READY);

endmodule : svd_startup_timer

// ===== dv/test_supply_voltage_detect_ctrl.sv
// Purpose: Self-checking bench for the supply voltage detector register block.
// Assumes: Start-up interval shortened to 4 cycles; only the watchdog ends a bus wait.
// Notes:   Tests are sequences of AXI4-Lite reads and writes with expected values.
`timescale 1ns/1ns
module test_supply_voltage_detect_ctrl;
  localparam int unsigned STARTUP = 4;
  localparam logic [15:0] BAD_ADDR = 16'h3CB4;

  logic        aclk;
  logic        aresetn;
  logic        por_reset;
  logic [15:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [15:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        supply_low;
  logic        global_irq_en;
  logic        monitor_on;
  logic [3:0]  trip_level;
  logic        wake_req;
  logic        irq;
  int          n_mismatch;
  int          samples_checked;
  logic [31:0] rd_val;
  logic [1:0]  rd_resp;

  `define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end

  svd_ctrl #(.STARTUP_CYCLES(STARTUP)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .por_reset(por_reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .supply_low(supply_low), .global_irq_en(global_irq_en),
    .monitor_on(monitor_on), .trip_level(trip_level),
    .wake_req(wake_req), .irq(irq)
  );

  // Free-running 125 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Write: address and data together, bready held until response seen
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready  <= 1'b0;
    `CHK(bresp, er)
  endtask : wr

  // Read: rready held until rvalid sampled, data taken at that edge
  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready  <= 1'b0;
    rd_val  = rdata;
    rd_resp = rresp;
  endtask : rd

  // Read and compare against an OKAY answer
  task automatic rchk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    `CHK(rd_resp, svd_pkg::RESP_OKAY)
    `CHK(rd_val, exp)
  endtask : rchk

  task automatic results;
    $display("counts: checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // Watchdog sized well above the expected run of some 150 cycles
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    results();
  end

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    samples_checked = 0;
    aresetn = 1'b0; por_reset = 1'b1; awaddr = 16'h0000; awvalid = 1'b0;
    wdata = 32'h0000_0000; wstrb = 4'h1; wvalid = 1'b0; bready = 1'b0;
    araddr = 16'h0000; arvalid = 1'b0; rready = 1'b0;
    supply_low = 1'b0; global_irq_en = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    por_reset <= 1'b0;

    // Reset values and unmapped access
    rchk(svd_pkg::CTRL_ADDR, 32'h0000_0000);
    rchk(svd_pkg::LEVEL_ADDR, 32'h0000_0000);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0000);
    rd(BAD_ADDR);
    `CHK(rd_resp, svd_pkg::RESP_SLVERR)
    `CHK(rd_val, 32'h0000_0000)
    wr(BAD_ADDR, 32'h0000_00FF, svd_pkg::RESP_SLVERR);
    $display("test reset_values done");

    // Level field, reserved code refused
    wr(svd_pkg::LEVEL_ADDR, 32'h0000_000E, svd_pkg::RESP_OKAY);
    `CHK(trip_level, 4'hE)
    wr(svd_pkg::LEVEL_ADDR, 32'h0000_000F, svd_pkg::RESP_OKAY);
    rchk(svd_pkg::LEVEL_ADDR, 32'h0000_000E);
    // Lane 0 strobe low: write ignored, still OKAY
    wstrb <= 4'h0;
    wr(svd_pkg::LEVEL_ADDR, 32'h0000_0005, svd_pkg::RESP_OKAY);
    wstrb <= 4'h1;
    rchk(svd_pkg::LEVEL_ADDR, 32'h0000_000E);
    $display("test level done");

    // Rise detection gated by start-up readiness
    // Setup order: direction and enable, then clear stale flag and enable interrupt
    wr(svd_pkg::CTRL_ADDR, 32'h0000_0082, svd_pkg::RESP_OKAY);
    `CHK(monitor_on, 1'b1)
    `CHK(wake_req, 1'b0)
    rchk(svd_pkg::CTRL_ADDR, 32'h0000_0082);
    // Read taken on the edge ready first stands, so no flag yet
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0000);
    wr(svd_pkg::IRQ_ADDR, 32'h0000_0003, svd_pkg::RESP_OKAY);
    repeat (2 * STARTUP + 4) @(posedge aclk);
    rchk(svd_pkg::CTRL_ADDR, 32'h0000_0092);
    `CHK(wake_req, 1'b1)
    `CHK(irq, 1'b0)
    global_irq_en <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    `CHK(irq, 1'b1)
    $display("test rise done");

    // Sticky flag re-sets, disable makes no event, fall off above limit
    wr(svd_pkg::IRQ_ADDR, 32'h0000_0003, svd_pkg::RESP_OKAY);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0003);
    wr(svd_pkg::CTRL_ADDR, 32'h0000_0000, svd_pkg::RESP_OKAY);
    wr(svd_pkg::IRQ_ADDR, 32'h0000_0003, svd_pkg::RESP_OKAY);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0002);
    `CHK(irq, 1'b0)
    wr(svd_pkg::CTRL_ADDR, 32'h0000_0081, svd_pkg::RESP_OKAY);
    repeat (2 * STARTUP + 4) @(posedge aclk);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0002);
    $display("test sticky done");

    // Fall detection and comparator bit
    supply_low <= 1'b1;
    repeat (3) @(posedge aclk);
    rchk(svd_pkg::CTRL_ADDR, 32'h0000_00B1);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0003);
    $display("test fall done");

    // Both directions flag either side of the limit
    wr(svd_pkg::CTRL_ADDR, 32'h0000_0000, svd_pkg::RESP_OKAY);
    wr(svd_pkg::CTRL_ADDR, 32'h0000_0083, svd_pkg::RESP_OKAY);
    repeat (2 * STARTUP + 4) @(posedge aclk);
    wr(svd_pkg::IRQ_ADDR, 32'h0000_0003, svd_pkg::RESP_OKAY);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0003);
    supply_low <= 1'b0;
    wr(svd_pkg::IRQ_ADDR, 32'h0000_0003, svd_pkg::RESP_OKAY);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0003);
    $display("test both done");

    // Device reset mid-run, then power-on reset
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK(monitor_on, 1'b0)
    `CHK(trip_level, 4'hE)
    rchk(svd_pkg::CTRL_ADDR, 32'h0000_0000);
    rchk(svd_pkg::IRQ_ADDR, 32'h0000_0000);
    por_reset <= 1'b1;
    @(posedge aclk);
    por_reset <= 1'b0;
    @(posedge aclk);
    `CHK(trip_level, 4'h0)
    $display("test resets done");
    results();
  end
endmodule : test_supply_voltage_detect_ctrl

// ===== pkg/svd_pkg.sv
// Purpose: Shared constants, register map and decode for the supply voltage detector.
// Assumes: AXI4-Lite byte addresses are four times the register index.
// Notes:   Registers are 8 bits wide in the low lane; upper bits read as zero.
package svd_pkg;

  // Clock and reference start-up timing
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned REF_STARTUP_NS = 25000;
  localparam int unsigned STARTUP_CYC    = (REF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices and byte addresses
  localparam logic [11:0] CTRL_IDX   = 12'hF2A;
  localparam logic [11:0] LEVEL_IDX  = 12'hF2B;
  localparam logic [11:0] IRQ_IDX    = 12'hF2C;
  localparam logic [15:0] CTRL_ADDR  = {2'h0, CTRL_IDX, 2'h0};
  localparam logic [15:0] LEVEL_ADDR = {2'h0, LEVEL_IDX, 2'h0};
  localparam logic [15:0] IRQ_ADDR   = {2'h0, IRQ_IDX, 2'h0};

  // Field positions of the control register
  localparam int unsigned ON_BIT   = 7;
  localparam int unsigned OUT_BIT  = 5;
  localparam int unsigned RDY_BIT  = 4;
  localparam int unsigned RISE_BIT = 1;
  localparam int unsigned FALL_BIT = 0;

  // Field positions of the interrupt register
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned IE_BIT   = 1;

  // Level field and reset values
  localparam int unsigned LEVEL_W        = 4;
  localparam logic [3:0]  LEVEL_RST      = 4'h0;
  localparam logic [3:0]  LEVEL_RESERVED = 4'hF;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SVD_SEL_NONE,
    SVD_SEL_CTRL,
    SVD_SEL_LEVEL,
    SVD_SEL_IRQ
  } svd_sel_e;

  // Address decode shared by read and write paths
  function automatic svd_sel_e svd_decode(input logic [15:0] addr);
    svd_sel_e sel;
    sel = SVD_SEL_NONE;
    if (addr == CTRL_ADDR)
      sel = SVD_SEL_CTRL;
    else if (addr == LEVEL_ADDR)
      sel = SVD_SEL_LEVEL;
    else if (addr == IRQ_ADDR)
      sel = SVD_SEL_IRQ;
    return sel;
  endfunction : svd_decode

endpackage : svd_pkg

// ===== pkg/svd_tmr_if.sv
// Purpose: Link between the control logic and the start-up timer.
// Assumes: Single clock domain.
// Notes:   arm is a level; ready is a level from the timer state.
`timescale 1ns/1ns
interface svd_tmr_if;
  logic arm;
  logic ready;

  modport ctrl  (output arm, input ready);
  modport timer (input arm, output ready);
endinterface : svd_tmr_if
